/* File: logic/crf_map.vh */
`ifndef CRF_MAP_VH
`define CRF_MAP_VH
// register indices (byte address = index * 4 not used: plain port, word index)
`define CRF_REG_CTRL      4'h0
`define CRF_REG_STATUS    4'h1
`define CRF_REG_ARG       4'h2
`define CRF_REG_CARDSTAT  4'h3
`define CRF_REG_TASKSTAT  4'h4
`define CRF_REG_OCR       4'h5
`define CRF_REG_RCA       4'h6
`define CRF_REG_IFCOND    4'h7
`define CRF_REG_LONG0     4'h8
`define CRF_REG_LONG3     4'hb
`define CRF_REG_EXTIDX    4'hc
`define CRF_REG_EXTDATA   4'hd
// response kinds in the control register
`define CRF_KIND_NORMAL   3'h0
`define CRF_KIND_BUSY     3'h1
`define CRF_KIND_LONG     3'h2
`define CRF_KIND_OCR      3'h3
`define CRF_KIND_RCA      3'h4
`define CRF_KIND_IFCOND   3'h5
// control register fields
`define CRF_CTRL_GO       0
`define CRF_CTRL_KIND_LSB 1
`define CRF_CTRL_KIND_MSB 3
`define CRF_CTRL_IDX_LSB  8
`define CRF_CTRL_IDX_MSB  13
`define CRF_CTRL_BUSYREL  16
// frame layout
`define CRF_SHORT_BITS    8'd48
`define CRF_LONG_BITS     8'd136
`define CRF_CRC_FROM      8'd40
`define CRF_ONES6         6'h3f
`define CRF_ONES7         7'h7f
`define CRF_IDX_RCA       6'h03
`define CRF_IDX_IFCOND    6'h08
`define CRF_IDX_STATREQ   6'h0d
`define CRF_ARG_TASKSEL   15
`define CRF_VOLT_HIGH     4'h1
`define CRF_STAT_USED     32'hfff9_ffff
`define CRF_EXT_WORDS     16
`endif

/* File: logic/crf_response_framer.v */
`timescale 1ns/10ps
`include "crf_map.vh"
// Overview of operation
// R1 - responses shift out on the command line, most significant bit first
// R2 - every frame opens with start bit 0 then direction bit 0
// R3 - crc7 covers all short frames except operating-conditions, which sends ones; long frames send content bits 7 to 1 unchanged, no crc computed
// R4 - last bit of every frame is end bit 1
// R5 - normal frame 48 bits, command index in bits 45 to 40
// R6 - normal frame: status in 39 to 8, crc7 in 7 to 1
// R7 - card may hold data line busy after each written block
// R8 - busy variant is normal format, busy on data line optional
// R9 - long frame 136 bits, bits 133 to 128 all ones
// R10 - long frame sends register bits 127 to 1, end bit replaces bit 0
// R11 - operating-conditions frame: index ones, register in 39 to 8, crc ones
// R12 - address frame index 000011, address high, selected status bits low
// R13 - interface frame index 001000, 39 to 22 zero, voltage and echo
// R14 - bit 21 low-rail support, bit 20 pcie acceptance, one means yes
// R15 - voltage field 0001 means 2.7 to 3.6 volt range
// R16 - interface frame only sent when the supply voltage is accepted
// R17 - status request bit 15 picks task status, otherwise card status
// R18 - a 512-bit extended status field is kept
// R19 - unused reserved card status bits go out as zero
// R20 - crc7 polynomial x7+x3+1, zero start, over frame bits 47 to 8
module crf_response_framer #(
  parameter EXT_WORDS = `CRF_EXT_WORDS          // extended status words of 32 bits
) (
  input  wire        ref_clk,                   // 125 MHz clock
  input  wire        reset,                     // synchronous, active high
  input  wire        clk_en,                    // freezes all state while low
  input  wire [3:0]  reg_addr,                  // register word index
  input  wire [31:0] reg_wdata,                 // write data
  input  wire        reg_wr,                    // write strobe
  input  wire        reg_rd,                    // read strobe
  output reg  [31:0] reg_rdata,                 // read data, cycle after strobe
  input  wire        block_done_pin,            // pulse-like pin: data block received
  input  wire        card_busy_pin,             // pin: card internals busy
  output reg         cmd_out,                   // command line data
  output reg         cmd_oe_n,                  // command line enable, low drives
  output reg         dat0_out,                  // data line 0 data
  output reg         dat0_oe_n                  // data line 0 enable, low drives
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_SHIFT = 2'h1;

  // register word map, as software sees it
  //   0 control: bit 0 go, 3:1 kind, 13:8 command index, 16 release busy
  //   1 status: 0 shifting, 1 done, 2 skipped, 3 busy held, 11:4 bits left
  //   2 argument of the command being answered
  //   3 card status, reserved bits masked on the way out
  //   4 queued task status
  //   5 operating-conditions word
  //   6 published relative address, low half
  //   7 interface condition: 7 low rail, 6 pcie, 3:0 host voltage
  //   8 to 11 long content, word 8 holds bits 31:0
  //   12 extended status word index
  //   13 extended status word data
  //   other indices read as zero and ignore writes
  //
  // response kinds written to control bits 3:1
  //   0 normal, 1 normal with busy, 2 long, 3 operating conditions,
  //   4 published address, 5 interface condition; 6 and 7 act as normal
  //
  // frame timing, counted in clock edges from the go write
  //   edge 0: go taken, shift register loaded, state moves to shifting
  //   edge 1: line enabled, start bit on the line
  //   edge 2: direction bit on the line
  //   edges 3 to 8: command index or reserved ones
  //   edge 48 (short) or 136 (long): end bit on the line
  //   one edge later the line is released; the done flag already stands from the end-bit edge
  //
  // the short frame sits in the low 48 bits of the shift register and is
  // taken from bit 47; the long frame uses all 136 bits and bit 135.
  // crc7 runs over the first 40 bits while they go out, so it is ready
  // exactly when its slot comes up and needs no second pass.
  // the crc slot is refilled from the running crc as the slot opens:
  // its top bit goes straight to the line, the other six and the end bit
  // are written into the shift positions that feed the line next.
  //
  // a long frame carries its content's own crc unchanged, and the
  // operating-conditions frame keeps its ones, so neither is refilled.
  //
  // busy on data line 0 is driven low while held; the line's pull-up
  // gives the idle level, so the pin is never driven high.
  // busy is held from a received block or a busy-variant frame until
  // software releases it; a block edge in the same cycle as the release
  // keeps busy, since losing a busy period would corrupt the next block.
  // while the last frame was the busy variant, the card-busy pin also
  // holds the data line low without software involvement.
  //
  // a go written while shifting is ignored: the frame on the line is
  // never cut, and software polls status bit 0 before the next go.
  // an interface frame whose host voltage is not accepted sends nothing
  // and sets the skipped flag instead.
  //
  // the status-request index with argument bit 15 set selects the queued
  // task status; the choice uses the index being written with go, not the
  // one of the frame before.
  //
  // both pins pass two flip-flops before any logic reads them.
  // the block-done pin is edge detected after the synchroniser, and the
  // detector starts from the pin's idle level so reset makes no edge.
  //
  // clk_en low freezes every register, including the synchronisers.

  reg [1:0]   state;
  reg [2:0]   kind;
  reg [5:0]   cmd_idx;
  reg [31:0]  arg;
  reg [31:0]  card_stat;
  reg [31:0]  task_stat;
  reg [31:0]  ocr;
  reg [15:0]  rca;
  reg [7:0]   ifcond;         // [7]=low rail [6]=pcie [3:0] host voltage
  reg [127:0] long_reg;
  reg [31:0]  ext_stat [0:EXT_WORDS-1];
  reg [3:0]   ext_idx;
  reg [135:0] shreg;
  reg [7:0]   bits_left;
  reg [6:0]   crc;
  reg         busy_hold;
  reg         skipped;
  reg         done_flag;
  reg [1:0]   blk_sync;
  reg [1:0]   bsy_sync;
  reg         blk_last;

  // one step of the crc7 shift register
  function [6:0] crc7_step;
    input [6:0] c;
    input       b;
    reg         fb;
    begin
      fb = c[6] ^ b;
      crc7_step = {c[5:3], c[2] ^ fb, c[1:0], fb};   // R20
    end
  endfunction

  // keep only the defined card status bits
  function [31:0] clean_stat;
    input [31:0] s;
    begin
      clean_stat = s & `CRF_STAT_USED;   // R19
    end
  endfunction

  wire [31:0] stat_word;
  wire        volt_ok;
  wire [31:0] rca_arg;
  wire [31:0] if_arg;
  wire [2:0]  wkind;
  wire        blk_rise;

  // R17
  // decided from the index that comes with go; cmd_idx still holds the last one
  assign stat_word = (reg_wdata[`CRF_CTRL_IDX_MSB:`CRF_CTRL_IDX_LSB] == `CRF_IDX_STATREQ &&
                      arg[`CRF_ARG_TASKSEL]) ?
                     task_stat : clean_stat(card_stat);
  assign volt_ok   = (ifcond[3:0] == `CRF_VOLT_HIGH);  // R15
  assign rca_arg   = {rca, card_stat[23], card_stat[22], card_stat[19], card_stat[12:0]}; // R12
  assign if_arg    = {18'h00000, ifcond[7], ifcond[6], ifcond[3:0], arg[7:0]}; // R13 R14
  assign wkind     = reg_wdata[`CRF_CTRL_KIND_MSB:`CRF_CTRL_KIND_LSB];
  assign blk_rise  = blk_sync[1] & ~blk_last;

  always @(posedge ref_clk) begin
    if (reset) begin
      blk_sync <= 2'h0;
      bsy_sync <= 2'h0;
      blk_last <= 1'b0;
    end else if (clk_en) begin
      blk_sync <= {blk_sync[0], block_done_pin};
      bsy_sync <= {bsy_sync[0], card_busy_pin};
      blk_last <= blk_sync[1];
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      state     <= ST_IDLE;
      kind      <= `CRF_KIND_NORMAL;
      cmd_idx   <= 6'h00;
      arg       <= 32'h0000_0000;
      card_stat <= 32'h0000_0000;
      task_stat <= 32'h0000_0000;
      ocr       <= 32'h0000_0000;
      rca       <= 16'h0000;
      ifcond    <= 8'h00;
      long_reg  <= 128'h0;
      ext_idx   <= 4'h0;
      shreg     <= 136'h0;
      bits_left <= 8'h00;
      crc       <= 7'h00;
      busy_hold <= 1'b0;
      skipped   <= 1'b0;
      done_flag <= 1'b0;
      reg_rdata <= 32'h0000_0000;
      cmd_out   <= 1'b1;
      cmd_oe_n  <= 1'b1;
      dat0_out  <= 1'b1;
      dat0_oe_n <= 1'b1;
    end else if (clk_en) begin
      // busy on data line: held after a received block or a busy-variant frame
      if (blk_rise) begin
        busy_hold <= 1'b1;   // R7
      end else if (reg_wr && reg_addr == `CRF_REG_CTRL && reg_wdata[`CRF_CTRL_BUSYREL]) begin
        busy_hold <= 1'b0;
      end
      dat0_oe_n <= ~(busy_hold | (bsy_sync[1] & kind == `CRF_KIND_BUSY)); // R7 R8
      dat0_out  <= 1'b0;

      if (reg_wr) begin
        case (reg_addr)
          `CRF_REG_ARG:      arg       <= reg_wdata;
          `CRF_REG_CARDSTAT: card_stat <= reg_wdata;
          `CRF_REG_TASKSTAT: task_stat <= reg_wdata;
          `CRF_REG_OCR:      ocr       <= reg_wdata;
          `CRF_REG_RCA:      rca       <= reg_wdata[15:0];
          `CRF_REG_IFCOND:   ifcond    <= reg_wdata[7:0];
          `CRF_REG_EXTIDX:   ext_idx   <= reg_wdata[3:0];
          `CRF_REG_EXTDATA:  ext_stat[ext_idx] <= reg_wdata;  // R18
          default: begin
            if (reg_addr >= `CRF_REG_LONG0 && reg_addr <= `CRF_REG_LONG3) begin
              long_reg[(reg_addr - `CRF_REG_LONG0) * 32 +: 32] <= reg_wdata;
            end
          end
        endcase
      end

      // status bit 1 set by hardware wins over clear by control write
      if (state == ST_SHIFT && bits_left == 8'd1) begin
        done_flag <= 1'b1;
      end else if (reg_wr && reg_addr == `CRF_REG_CTRL) begin
        done_flag <= 1'b0;
      end

      case (state)
        ST_IDLE: begin
          cmd_oe_n <= 1'b1;
          cmd_out  <= 1'b1;
          if (reg_wr && reg_addr == `CRF_REG_CTRL && reg_wdata[`CRF_CTRL_GO]) begin
            kind    <= wkind;
            cmd_idx <= reg_wdata[`CRF_CTRL_IDX_MSB:`CRF_CTRL_IDX_LSB];
            crc     <= 7'h00;
            skipped <= 1'b0;
            case (wkind)
              `CRF_KIND_LONG: begin
                shreg     <= {2'b00, `CRF_ONES6, long_reg[127:1], 1'b1}; // R9 R10
                bits_left <= `CRF_LONG_BITS;
                state     <= ST_SHIFT;
              end
              `CRF_KIND_OCR: begin
                shreg     <= {88'h0, 2'b00, `CRF_ONES6, ocr, `CRF_ONES7, 1'b1}; // R11
                bits_left <= `CRF_SHORT_BITS;
                state     <= ST_SHIFT;
              end
              `CRF_KIND_RCA: begin
                shreg     <= {88'h0, 2'b00, `CRF_IDX_RCA, rca_arg, 8'h01}; // R12
                bits_left <= `CRF_SHORT_BITS;
                state     <= ST_SHIFT;
              end
              `CRF_KIND_IFCOND: begin
                if (volt_ok) begin   // R16
                  shreg     <= {88'h0, 2'b00, `CRF_IDX_IFCOND, if_arg, 8'h01}; // R13
                  bits_left <= `CRF_SHORT_BITS;
                  state     <= ST_SHIFT;
                end else begin
                  skipped <= 1'b1;
                end
              end
              `CRF_KIND_BUSY: begin
                // same layout as normal; busy starts with the frame
                busy_hold <= 1'b1;   // R8
                shreg     <= {88'h0, 2'b00, reg_wdata[`CRF_CTRL_IDX_MSB:`CRF_CTRL_IDX_LSB],
                              stat_word, 8'h01};
                bits_left <= `CRF_SHORT_BITS;
                state     <= ST_SHIFT;
              end
              default: begin
                // R2 R4 R5 R6
                shreg     <= {88'h0, 2'b00, reg_wdata[`CRF_CTRL_IDX_MSB:`CRF_CTRL_IDX_LSB],
                              stat_word, 8'h01};
                bits_left <= `CRF_SHORT_BITS;
                state     <= ST_SHIFT;
              end
            endcase
          end
        end
        ST_SHIFT: begin
          cmd_oe_n  <= 1'b0;
          bits_left <= bits_left - 8'd1;
          // the frame's top bit sits at the width's top position
          if (bits_left == 8'd8 && kind != `CRF_KIND_OCR && kind != `CRF_KIND_LONG) begin
            cmd_out <= crc[6];   // R3
            shreg   <= {shreg[134:0], 1'b0};
            shreg[47:41] <= {crc[5:0], 1'b1};   // R4
          end else if (bits_left == 8'd8 && kind == `CRF_KIND_OCR) begin
            cmd_out <= shreg[47];   // R3
            shreg   <= {shreg[134:0], 1'b0};
          end else begin
            cmd_out <= (kind == `CRF_KIND_LONG) ? shreg[135] : shreg[47];  // R1
            shreg   <= {shreg[134:0], 1'b0};
          end
          if (bits_left > `CRF_SHORT_BITS - `CRF_CRC_FROM && kind != `CRF_KIND_LONG) begin
            crc <= crc7_step(crc, shreg[47]);   // R20
          end
          if (bits_left == 8'd1) begin
            state <= ST_IDLE;   // R4
          end
        end
        default: state <= ST_IDLE;
      endcase

      if (reg_rd) begin
        case (reg_addr)
          `CRF_REG_CTRL:     reg_rdata <= {16'h0, 2'h0, cmd_idx, 4'h0, kind, 1'b0};
          `CRF_REG_STATUS:   reg_rdata <= {20'h0, bits_left, busy_hold, skipped, done_flag,
                                           state == ST_SHIFT};
          `CRF_REG_ARG:      reg_rdata <= arg;
          `CRF_REG_CARDSTAT: reg_rdata <= clean_stat(card_stat);
          `CRF_REG_TASKSTAT: reg_rdata <= task_stat;
          `CRF_REG_OCR:      reg_rdata <= ocr;
          `CRF_REG_RCA:      reg_rdata <= {16'h0, rca};
          `CRF_REG_IFCOND:   reg_rdata <= {24'h0, ifcond};
          `CRF_REG_EXTIDX:   reg_rdata <= {28'h0, ext_idx};
          `CRF_REG_EXTDATA:  reg_rdata <= ext_stat[ext_idx];
          default: begin
            if (reg_addr >= `CRF_REG_LONG0 && reg_addr <= `CRF_REG_LONG3) begin
              reg_rdata <= long_reg[(reg_addr - `CRF_REG_LONG0) * 32 +: 32];
            end else begin
              reg_rdata <= 32'h0000_0000;
            end
          end
        endcase
      end
    end
  end
endmodule // crf_response_framer

/* File: sim/crf_host_model.sv */
`timescale 1ns/10ps
module crf_host_model (
  input  wire         ref_clk,           // clock
  input  wire         cmd_out,           // cmd data
  input  wire         cmd_oe_n,          // cmd enable
  input  wire         dat0_out,          // dat0 data
  input  wire         dat0_oe_n,         // dat0 enable
  output reg  [135:0] frame = 136'h0,    // last bits
  output reg  [7:0]   nbits = 8'h00,     // frame length
  output reg  [7:0]   nframes = 8'h00,   // frames seen
  output wire         busy_seen          // dat0 busy
);
  reg in_frame = 1'b0;
  // dat0 is pulled up, so only a driven low counts as busy
  assign busy_seen = !dat0_oe_n && !dat0_out;
  always @(posedge ref_clk) begin
    in_frame <= !cmd_oe_n;
    if (!cmd_oe_n) begin
      frame <= {frame[134:0], cmd_out};
      nbits <= in_frame ? nbits + 8'h01 : 8'h01;
    end
    if (in_frame && cmd_oe_n)
      nframes <= nframes + 8'h01;
  end
endmodule // crf_host_model

/* File: sim/crf_response_framer_tb.sv */
`timescale 1ns/10ps
module crf_response_framer_tb;
  reg          ref_clk = 1'b0;
  reg          reset = 1'b1;
  reg  [3:0]   reg_addr = 4'h0;
  reg  [31:0]  reg_wdata = 32'h0;
  reg          reg_wr = 1'b0;
  reg          reg_rd = 1'b0;
  reg          block_done_pin = 1'b0;
  reg          card_busy_pin = 1'b0;
  wire [31:0]  reg_rdata;
  wire         cmd_out, cmd_oe_n, dat0_out, dat0_oe_n, busy_seen;
  wire [135:0] frame;
  wire [7:0]   nbits, nframes;
  integer      n_fail = 0, n_checks = 0, k;
  reg  [31:0]  v;
  reg  [7:0]   n0;
  crf_response_framer DUT (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .block_done_pin(block_done_pin), .card_busy_pin(card_busy_pin),
    .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n), .dat0_out(dat0_out), .dat0_oe_n(dat0_oe_n));
  crf_host_model host (.ref_clk(ref_clk), .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n),
    .dat0_out(dat0_out), .dat0_oe_n(dat0_oe_n), .frame(frame), .nbits(nbits),
    .nframes(nframes), .busy_seen(busy_seen));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task chk(input [135:0] got, input [135:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // crc7 with x^7+x^3+1, zero start, over frame bits 47 to 8
  function [47:0] sf(input [5:0] i, input [31:0] a);
    reg [39:0] d;
    reg [6:0]  c;
    integer    j;
    begin
      d = {2'b00, i, a};
      c = 7'h00;
      for (j = 39; j >= 0; j = j - 1) begin
        c = {c[5:0], 1'b0} ^ ((d[j] ^ c[6]) ? 7'h09 : 7'h00);
      end
      sf = {d, c, 1'b1};
    end
  endfunction
  task send(input [2:0] kind, input [5:0] idx, input [7:0] len, input [135:0] exp);
    n0 = nframes;
    wr(4'h0, {18'h0, idx, 4'h0, kind, 1'b1});
    for (k = 0; k < 300 && nframes === n0; k = k + 1) @(posedge ref_clk);
    if (nframes === n0) begin
      n_fail = n_fail + 1;
      print_verdict;
    end
    chk(nbits, len);
    chk(len == 8'd48 ? {88'h0, frame[47:0]} : frame, exp);
    repeat (2) @(posedge ref_clk);
  endtask
  task wbusy(input b);
    for (k = 0; k < 300 && busy_seen !== b; k = k + 1) @(posedge ref_clk);
    chk(busy_seen, b);
    if (busy_seen !== b) print_verdict;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rd(4'hf);
    chk(v, 32'h0);
    wr(4'h3, 32'hffff_ffff);
    send(3'h0, 6'h11, 48, sf(6'h11, 32'hfff9_ffff));
    wr(4'h4, 32'h1234_5678);
    wr(4'h2, 32'h0000_80a5);
    send(3'h0, 6'h0d, 48, sf(6'h0d, 32'h1234_5678));
    card_busy_pin <= 1'b1;
    send(3'h1, 6'h07, 48, sf(6'h07, 32'hfff9_ffff));
    wbusy(1'b1);
    card_busy_pin <= 1'b0;
    wr(4'h0, 32'h0001_0000);
    wbusy(1'b0);
    wr(4'h5, 32'h80ff_8000);
    send(3'h3, 6'h00, 48, {2'b00, 6'h3f, 32'h80ff_8000, 8'hff});
    wr(4'h3, 32'h00c8_1234);
    wr(4'h6, 32'habcd_abcd);
    send(3'h4, 6'h00, 48, sf(6'h03, 32'habcd_f234));
    wr(4'h8, 32'h8765_4320);
    wr(4'h9, 32'h0bad_f00d);
    wr(4'ha, 32'h1357_9bdf);
    wr(4'hb, 32'h2468_ace0);
    send(3'h2, 6'h00, 136, {8'h3f, 96'h2468ace0_13579bdf_0badf00d, 31'h43b2_a190, 1'b1});
    wr(4'h7, 32'h0000_0041);
    send(3'h5, 6'h00, 48, sf(6'h08, {18'h0, 2'b01, 4'h1, 8'ha5}));
    wr(4'h7, 32'h0000_0002);
    n0 = nframes;
    wr(4'h0, 32'h0000_000b);
    repeat (60) @(posedge ref_clk);
    chk(nframes, n0);
    rd(4'h1);
    chk(v[2], 1'b1);
    chk(v[1:0], 2'b00);
    wr(4'hc, 32'h5);
    wr(4'hd, 32'hdead_beef);
    wr(4'hc, 32'h5);
    rd(4'hd);
    chk(v, 32'hdead_beef);
    block_done_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    block_done_pin <= 1'b0;
    wbusy(1'b1);
    wr(4'h0, 32'h0001_0000);
    wbusy(1'b0);
    print_verdict;
  end
endmodule // crf_response_framer_tb

/* File: sim/crf_response_properties.sv */
`timescale 1ns/10ps
`include "crf_map.vh"
module crf_response_properties (
  input wire        ref_clk,   // clock
  input wire        reset,     // sync reset
  input wire [3:0]  reg_addr,  // index
  input wire [31:0] reg_wdata, // data
  input wire        reg_wr,    // strobe
  input wire        cmd_out,   // cmd data
  input wire        cmd_oe_n,  // cmd enable
  input wire        dat0_out,  // dat0 data
  input wire        dat0_oe_n  // dat0 enable
);
  reg [7:0] cnt;
  wire      go;
  assign go = reg_wr && reg_addr == `CRF_REG_CTRL && reg_wdata[0] && cmd_oe_n;
  // counts driven cycles; cleared on the edge after the line is released
  always @(posedge ref_clk) begin
    cnt <= (reset || cmd_oe_n) ? 8'h00 : cnt + 8'h01;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  start_bit_a: assert property ($fell(cmd_oe_n) |-> !cmd_out)
    else $error("start bit not zero");
  dir_bit_a: assert property ($fell(cmd_oe_n) |=> !cmd_oe_n && !cmd_out)
    else $error("direction bit not zero");
  end_bit_a: assert property ($rose(cmd_oe_n) |-> $past(cmd_out))
    else $error("end bit not one");
  frame_len_a: assert property ($rose(cmd_oe_n) |-> cnt == 8'd48 || cnt == 8'd136)
    else $error("frame length wrong");
  frame_hold_a: assert property (!cmd_oe_n && cnt < 8'd47 |=> !cmd_oe_n)
    else $error("frame cut short");
  frame_start_a: assert property (go && reg_wdata[3:1] != `CRF_KIND_IFCOND |-> ##2 !cmd_oe_n)
    else $error("frame did not start");
  busy_low_a: assert property (!dat0_oe_n |-> !dat0_out)
    else $error("busy level not low");
  ocr_fixed_a: assert property (go && reg_wdata[3:1] == `CRF_KIND_OCR |-> ##4 cmd_out[*6] ##33 cmd_out[*8])
    else $error("fixed ones missing");
  long_rsvd_a: assert property (go && reg_wdata[3:1] == `CRF_KIND_LONG |-> ##4 cmd_out[*6])
    else $error("reserved ones missing");
  cover property (go && reg_wdata[3:1] == `CRF_KIND_OCR);
  cover property ($rose(cmd_oe_n) && cnt == 8'd136);
  cover property (!dat0_oe_n);
endmodule // crf_response_properties
bind crf_response_framer crf_response_properties u_props (.ref_clk(ref_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .cmd_out(cmd_out),
  .cmd_oe_n(cmd_oe_n), .dat0_out(dat0_out), .dat0_oe_n(dat0_oe_n));
